// ### pkg/flash_erase_pkg.sv
// constants and carrier types for the flash erase and status controller
// assumes one system clock; the flash array is reached by a simple strobe port
package flash_erase_pkg;
   localparam int ADDR_W           = 32;
   localparam int SECTOR_SHIFT     = 12;                 // 4KB sector
   localparam int SECTORS_PER_BANK = 32;
   localparam int INFO_SECTORS     = 2;
   localparam int WAIT_W           = 4;
   localparam int ERASE_TIME_NS    = 400;
   localparam int CLK_PERIOD_NS    = 4;
   localparam int ERASE_CYCLES     = (ERASE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [7:0] FLAGS_RESET = 8'h00;
   localparam logic [7:0] ENABLE_RESET = 8'h00;
   localparam logic [3:0] WAIT_RESET  = 4'h0;
   localparam int BIT_PROG_ERR = 0;
   localparam int BIT_BENCH    = 1;
   localparam int BIT_ERASE    = 2;
   localparam int BIT_BURST_WR = 3;
   localparam int BIT_WORD_WR  = 4;
   localparam int BIT_AFTER    = 5;
   localparam int BIT_BEFORE   = 6;
   localparam int BIT_CMP      = 7;

   typedef enum logic [2:0] {
      normal_read_setting, low_margin_read_setting, high_margin_read_setting,
      prog_check_read_setting, erase_check_read_setting, leak_check_read_setting,
      low_margin_alt_read_setting, high_margin_alt_read_setting
   } read_mode_t;

   // bank index: 0 first_bank, 1 second_bank
   typedef struct packed {
      read_mode_t        mode;
      logic [WAIT_W-1:0] wait_states;
   } bank_cfg_t;

   // one erase command from the core
   typedef struct packed {
      logic              start_sector;
      logic              start_mass;
      logic              info_region;
      logic [ADDR_W-1:0] addr;
   } erase_req_t;

   // strobe toward the array; one sector at a time
   typedef struct packed {
      logic       go;
      logic       info_region;
      logic       bank;
      logic [4:0] sector;
   } array_cmd_t;
endpackage

// ### hdl/flash_erase_ctrl.sv
// flash erase sequencer with sticky event flags, enables and per-bank settings
// assumes the array acks each sector erase with a one-cycle done pulse
// Summary of operation
// - erase in whole 4KB sectors only, never smaller
// - unaligned sector address erases the whole containing sector
// - sector erase accepted for main and information regions
// - eight raw event flags in the status word
// - masked status is raw flags ANDed with enables
// - each bank holds a readable eight-way read mode
// - each bank holds its own readable wait-state count
// - mass erase runs alone and sets erase-complete at end
// - per-sector protection state readable
// - only enabled flags drive the interrupt line
// - mass erase skips protected sectors
`timescale 1ns/10ps
`default_nettype none
module flash_erase_ctrl
   import flash_erase_pkg::*;
(
   input  wire logic                                  clk,
   input  wire logic                                  rstn,
   input  wire flash_erase_pkg::erase_req_t           req,
   input  wire logic [7:0]                            flag_clear,
   input  wire logic [7:0]                            side_events,
   input  wire logic [7:0]                            enable_wdata,
   input  wire logic                                  enable_we,
   input  wire logic                                  cfg_we,
   input  wire logic                                  cfg_bank,
   input  wire flash_erase_pkg::bank_cfg_t            cfg_wdata,
   input  wire logic [2*SECTORS_PER_BANK-1:0]         main_protect,
   input  wire logic [INFO_SECTORS-1:0]               info_protect,
   input  wire logic                                  array_done,
   output logic                                       busy,
   output logic [1:0]                                 bank_busy,
   output logic [7:0]                                 raw_flags,
   output logic [7:0]                                 masked_flags,
   output logic [7:0]                                 enables,
   output logic                                       irq,
   output flash_erase_pkg::bank_cfg_t                 bank0_cfg,
   output flash_erase_pkg::bank_cfg_t                 bank1_cfg,
   output logic [2*SECTORS_PER_BANK-1:0]              main_protect_q,
   output logic [INFO_SECTORS-1:0]                    info_protect_q,
   output flash_erase_pkg::array_cmd_t                array_cmd
);
   import flash_erase_pkg::*;

   typedef enum logic [1:0] {st_idle, st_issue, st_wait} state_t;

   typedef struct packed {
      state_t                         st;
      logic                           mass;
      logic                           info;
      logic [5:0]                     idx;
      logic [7:0]                     flags;
      logic [7:0]                     en;
      bank_cfg_t                      b0;
      bank_cfg_t                      b1;
      logic [2*SECTORS_PER_BANK-1:0]  mprot;
      logic [INFO_SECTORS-1:0]        iprot;
      array_cmd_t                     cmd;
      logic                           irq;
      logic [7:0]                     masked;
      logic                           busy;
      logic [1:0]                     bbusy;
   } regs_t;

   regs_t s_r, s_nxt;

   function automatic logic is_protected(input logic info, input logic [5:0] idx,
                                         input logic [2*SECTORS_PER_BANK-1:0] mp,
                                         input logic [INFO_SECTORS-1:0] ip);
      if (info)
         return ip[idx[0]];
      return mp[idx];
   endfunction

   logic [7:0] ev;
   logic       last_idx;

   // protection inputs are re-timed here, so a change takes effect one cycle late
   always_comb begin
      s_nxt = s_r;
      // erase-complete only comes from the sequencer, never from the side port
      ev = side_events & ~(8'h01 << BIT_ERASE);
      s_nxt.cmd.go = 1'b0;
      s_nxt.mprot = main_protect;
      s_nxt.iprot = info_protect;
      last_idx = s_r.info ? (s_r.idx == 6'(INFO_SECTORS-1))
                          : (s_r.idx == 6'(2*SECTORS_PER_BANK-1));
      if (enable_we)
         s_nxt.en = enable_wdata;
      if (cfg_we && !cfg_bank)
         s_nxt.b0 = cfg_wdata;
      if (cfg_we && cfg_bank)
         s_nxt.b1 = cfg_wdata;
      unique case (s_r.st)
         st_idle: begin
            // mass wins when both starts arrive together
            if (req.start_mass) begin
               s_nxt.mass = 1'b1;
               s_nxt.info = 1'b0;
               s_nxt.idx  = 6'h00;
               s_nxt.st   = st_issue;
            end else if (req.start_sector) begin
               s_nxt.mass = 1'b0;
               s_nxt.info = req.info_region;
               // low 12 address bits dropped: whole sector only
               s_nxt.idx  = req.info_region ? 6'(req.addr[SECTOR_SHIFT])
                                            : req.addr[SECTOR_SHIFT +: 6];
               s_nxt.st   = st_issue;
            end
         end
         st_issue: begin
            if (is_protected(s_r.info, s_r.idx, s_r.mprot, s_r.iprot)) begin
               if (!s_r.mass)
                  ev[BIT_PROG_ERR] = 1'b1;
               if (!s_r.mass || (s_r.info && last_idx)) begin
                  ev[BIT_ERASE] = s_r.mass;
                  s_nxt.st = st_idle;
               end else if (last_idx) begin
                  s_nxt.info = 1'b1;
                  s_nxt.idx  = 6'h00;
               end else
                  s_nxt.idx = s_r.idx + 6'h01;
            end else begin
               s_nxt.cmd.go          = 1'b1;
               s_nxt.cmd.info_region = s_r.info;
               s_nxt.cmd.bank        = s_r.info ? 1'b0 : s_r.idx[5];
               s_nxt.cmd.sector      = s_r.info ? 5'(s_r.idx[0]) : s_r.idx[4:0];
               s_nxt.st              = st_wait;
            end
         end
         st_wait: begin
            if (array_done) begin
               if (!s_r.mass || (s_r.info && last_idx)) begin
                  ev[BIT_ERASE] = 1'b1;
                  s_nxt.st = st_idle;
               end else begin
                  if (last_idx) begin
                     s_nxt.info = 1'b1;
                     s_nxt.idx  = 6'h00;
                  end else
                     s_nxt.idx = s_r.idx + 6'h01;
                  s_nxt.st = st_issue;
               end
            end
         end
      endcase
      // set beats clear in the same cycle
      s_nxt.flags  = (s_r.flags & ~flag_clear) | ev;
      s_nxt.masked = s_nxt.flags & s_nxt.en;
      s_nxt.irq    = |(s_nxt.flags & s_nxt.en);
      // core keeps off an erasing bank itself; info sectors sit in the first bank
      s_nxt.busy   = (s_nxt.st != st_idle);
      if (s_nxt.st == st_idle)
         s_nxt.bbusy = 2'h0;
      else if (s_nxt.mass)
         s_nxt.bbusy = 2'h3;
      else if (s_nxt.info || !s_nxt.idx[5])
         s_nxt.bbusy = 2'h1;
      else
         s_nxt.bbusy = 2'h2;
   end

   always_ff @(posedge clk) begin
      if (!rstn) begin
         s_r       <= '0;
         s_r.st    <= st_idle;
         s_r.flags <= FLAGS_RESET;
         s_r.en    <= ENABLE_RESET;
         s_r.b0    <= '{mode: normal_read_setting, wait_states: WAIT_RESET};
         s_r.b1    <= '{mode: normal_read_setting, wait_states: WAIT_RESET};
      end else
         s_r <= s_nxt;
   end

   assign busy           = s_r.busy;
   assign bank_busy      = s_r.bbusy;
   assign raw_flags      = s_r.flags;
   assign masked_flags   = s_r.masked;
   assign enables        = s_r.en;
   assign irq            = s_r.irq;
   assign bank0_cfg      = s_r.b0;
   assign bank1_cfg      = s_r.b1;
   assign main_protect_q = s_r.mprot;
   assign info_protect_q = s_r.iprot;
   assign array_cmd      = s_r.cmd;

   AST_MASKED: assert property (@(posedge clk) disable iff (!rstn)
      masked_flags == (raw_flags & enables)) else $error("masked status wrong");
   AST_IRQ: assert property (@(posedge clk) disable iff (!rstn)
      irq == |(raw_flags & enables)) else $error("irq not gated by enables");
   AST_STICKY: assert property (@(posedge clk) disable iff (!rstn)
      (raw_flags[BIT_ERASE] && !flag_clear[BIT_ERASE]) |=> raw_flags[BIT_ERASE])
      else $error("flag dropped without clear");
   AST_PROT_ERR: assert property (@(posedge clk) disable iff (!rstn)
      (s_r.st == st_issue && !s_r.mass && is_protected(s_r.info, s_r.idx, s_r.mprot, s_r.iprot))
      |=> raw_flags[BIT_PROG_ERR] && !array_cmd.go) else $error("protected erase not refused");
   AST_MASS_SKIP: assert property (@(posedge clk) disable iff (!rstn)
      (s_r.st == st_issue && is_protected(s_r.info, s_r.idx, s_r.mprot, s_r.iprot))
      |=> !array_cmd.go) else $error("protected sector erased");
   AST_DONE: assert property (@(posedge clk) disable iff (!rstn)
      (s_r.st == st_wait && array_done && (!s_r.mass || (s_r.info && last_idx)))
      |=> raw_flags[BIT_ERASE] && !busy) else $error("erase complete not flagged");
   AST_SECTOR: assert property (@(posedge clk) disable iff (!rstn)
      (s_r.st == st_idle && req.start_sector && !req.start_mass && !req.info_region)
      |=> s_r.idx == $past(req.addr[SECTOR_SHIFT +: 6])) else $error("wrong sector chosen");
   AST_CFG: assert property (@(posedge clk) disable iff (!rstn)
      (cfg_we && !cfg_bank) |=> bank0_cfg == $past(cfg_wdata)) else $error("bank cfg lost");
   AST_ONE_GO: assert property (@(posedge clk) disable iff (!rstn)
      array_cmd.go |=> !array_cmd.go) else $error("sector strobe longer than one cycle");
   AST_BANK_MASS: assert property (@(posedge clk) disable iff (!rstn)
      (busy && s_r.mass) |-> bank_busy == 2'h3) else $error("mass erase not shown on both banks");
   COV_SECTOR: cover property (@(posedge clk) disable iff (!rstn) array_cmd.go && !s_r.mass);
   COV_MASS: cover property (@(posedge clk) disable iff (!rstn) s_r.mass && raw_flags[BIT_ERASE]);
   COV_PROT: cover property (@(posedge clk) disable iff (!rstn) raw_flags[BIT_PROG_ERR]);
   COV_INFO: cover property (@(posedge clk) disable iff (!rstn) array_cmd.go && array_cmd.info_region);
endmodule
`default_nettype wire

// ### bench/flash_array_model.sv
// stand-in for the flash array behind the erase controller
// assumes one go strobe at a time; answers after a chosen delay
`timescale 1ns/10ps
`default_nettype none
module flash_array_model
   import flash_erase_pkg::*;
(
   input  wire logic                        clk,
   input  wire logic                        rstn,
   input  wire flash_erase_pkg::array_cmd_t cmd,
   input  wire logic [3:0]                  delay,
   output logic                             done,
   output var int                           n_go,
   output flash_erase_pkg::array_cmd_t      last
);
   import flash_erase_pkg::*;

   logic [4:0] cnt_r;
   always_ff @(posedge clk) begin
      done <= 1'b0;
      if (!rstn) begin
         cnt_r <= 5'h00;
         n_go <= 0;
         last <= '0;
      end else if (cmd.go) begin
         last <= cmd;
         n_go <= n_go + 1;
         cnt_r <= {1'b0, delay} + 5'h01;
      end else if (cnt_r == 5'h01) begin
         done <= 1'b1;
         cnt_r <= 5'h00;
      end else if (cnt_r != 5'h00) begin
         cnt_r <= cnt_r - 5'h01;
      end
   end
endmodule
`default_nettype wire

// ### bench/flash_erase_and_status_control_tb_top.sv
// self-checking bench for the flash erase and status controller
// assumes the array stand-in model; bench plays the requesting core
`timescale 1ns/10ps
`default_nettype none
module flash_erase_and_status_control_tb_top;
   import flash_erase_pkg::*;
   logic clk = 0, rstn = 0, enable_we = 0, cfg_we = 0, cfg_bank = 0, done;
   logic [7:0] flag_clear = 0, side_events = 0, enable_wdata = 0, raw, msk, en;
   logic [63:0] mp = 0, mpq;
   logic [1:0] ip = 0, ipq, bank_busy, bb;
   logic [3:0] delay = 0;
   logic busy, irq;
   erase_req_t req = '0;
   bank_cfg_t cfg_wdata = '0, b0, b1;
   array_cmd_t cmd, last;
   int n_go, mismatches = 0, n_compared = 0, cycles = 0, g;
   always #2 clk = ~clk;
   flash_erase_ctrl u_dut (.clk(clk), .rstn(rstn), .req(req), .flag_clear(flag_clear),
      .side_events(side_events), .enable_wdata(enable_wdata), .enable_we(enable_we),
      .cfg_we(cfg_we), .cfg_bank(cfg_bank), .cfg_wdata(cfg_wdata), .main_protect(mp),
      .info_protect(ip), .array_done(done), .busy(busy), .bank_busy(bank_busy),
      .raw_flags(raw), .masked_flags(msk), .enables(en), .irq(irq), .bank0_cfg(b0),
      .bank1_cfg(b1), .main_protect_q(mpq), .info_protect_q(ipq), .array_cmd(cmd));
   flash_array_model u_arr (.clk(clk), .rstn(rstn), .cmd(cmd), .delay(delay),
      .done(done), .n_go(n_go), .last(last));
   task automatic close_out();
      $display("compared %0d mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
      n_compared++;
      if (seen !== exp) begin
         mismatches++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         mismatches++;
         close_out();
      end
   end
   // bench never touches the bank under erase; it only waits for idle
   task automatic erase(input logic mass, input logic info, input logic [31:0] a);
      @(posedge clk);
      req <= '{~mass, mass, info, a};
      @(posedge clk);
      req <= '0;
      for (int i = 0; i < 3000; i++) begin
         @(posedge clk);
         if (i == 0)
            bb = bank_busy;
         if (busy === 1'b0) break;
      end
      g = n_go;
   endtask
   task automatic clr(input logic [7:0] m);
      @(posedge clk);
      flag_clear <= m;
      @(posedge clk);
      flag_clear <= 8'h00;
      repeat (2) @(posedge clk);
   endtask
   task automatic t_sector();
      int n0;
      n0 = n_go;
      erase(0, 0, 32'h0002_3ABC);
      chk({last.go, last.info_region, last.bank, last.sector}, {1'b1, 1'b0, 1'b1, 5'h03});
      chk(g - n0, 1);
      chk(bb, 2'h2);
      chk(raw[BIT_ERASE], 1'b1);
      // core sets the erased bank to erase-check read mode once complete is seen
      @(posedge clk);
      cfg_we <= 1'b1;
      cfg_bank <= 1'b1;
      cfg_wdata <= '{erase_check_read_setting, WAIT_RESET};
      @(posedge clk);
      cfg_we <= 1'b0;
      repeat (2) @(posedge clk);
      chk(b1.mode, erase_check_read_setting);
      clr(8'h04);
      erase(0, 1, 32'h0000_1FFF);
      chk({last.info_region, last.bank, last.sector}, {1'b1, 1'b0, 5'h01});
      chk(bb, 2'h1);
      clr(8'h04);
   endtask
   task automatic t_protect();
      int n0;
      mp <= 64'h0000_0000_0000_0020;
      ip <= 2'h2;
      repeat (3) @(posedge clk);
      chk(mpq, 64'h0000_0000_0000_0020);
      chk(ipq, 2'h2);
      n0 = n_go;
      erase(0, 0, 32'h0000_5010);
      chk(g - n0, 0);
      chk(raw[BIT_PROG_ERR], 1'b1);
      clr(8'h01);
      delay <= 4'h3;
      n0 = n_go;
      erase(1, 0, 32'h0000_0000);
      chk(g - n0, 2 * SECTORS_PER_BANK + INFO_SECTORS - 2);
      chk(bb, 2'h3);
      chk(raw, 8'h04);
      clr(8'h04);
      delay <= 4'h0;
      mp <= '0;
      ip <= '0;
   endtask
   task automatic t_flags();
      @(posedge clk);
      side_events <= 8'hFF;
      enable_we <= 1'b1;
      enable_wdata <= 8'h0A;
      @(posedge clk);
      side_events <= 8'h00;
      enable_we <= 1'b0;
      repeat (6) @(posedge clk);
      chk(raw, 8'hFB);
      chk(en, 8'h0A);
      chk(msk, 8'h0A);
      chk(irq, 1'b1);
      clr(8'h0A);
      chk(raw, 8'hF1);
      chk({msk, irq}, 9'h000);
      clr(8'hFF);
      // event and clear in one cycle: the event must win
      @(posedge clk);
      side_events <= 8'h10;
      flag_clear <= 8'h10;
      @(posedge clk);
      side_events <= 8'h00;
      flag_clear <= 8'h00;
      repeat (2) @(posedge clk);
      chk(raw, 8'h10);
      clr(8'hFF);
   endtask
   task automatic t_cfg();
      for (int i = 0; i < 8; i++) begin
         @(posedge clk);
         cfg_we <= 1'b1;
         cfg_bank <= 1'b0;
         cfg_wdata <= '{read_mode_t'(i), 4'(i + 3)};
         @(posedge clk);
         cfg_bank <= 1'b1;
         cfg_wdata <= '{read_mode_t'(7 - i), 4'(12 - i)};
         @(posedge clk);
         cfg_we <= 1'b0;
         repeat (2) @(posedge clk);
         chk(b0, {3'(i), 4'(i + 3)});
         chk(b1, {3'(7 - i), 4'(12 - i)});
      end
   endtask
   initial begin
      repeat (16) @(posedge clk);
      rstn <= 1'b1;
      @(posedge clk);
      chk({raw, msk, en, irq, b0, b1, busy, bank_busy}, '0);
      t_sector();
      t_protect();
      t_flags();
      t_cfg();
      close_out();
   end
endmodule
`default_nettype wire
